// ### design/access_level_protection_check.sv
// access level protection checker between the processor bus and the table walker
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "access_level_regs.svh"
module access_level_protection_check
  import access_level_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // processor bus cycle
  input wire logic cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire logic [3:0] cyc_func_code,
  input wire logic cyc_write,
  output logic bus_error,
  output logic [31:0] phys_addr,
  output logic phys_valid,
  // translation cache lookup result
  input wire logic cache_hit,
  input wire logic cache_fault,
  input wire logic cache_wlock,
  input wire logic [31:0] cache_phys,
  // walk request
  output logic walk_start,
  output logic [31:0] walk_root,
  output logic [31:0] walk_index_addr,
  output logic [14:0] walk_first_index,
  output logic [2:0] walk_level,
  output logic walk_busy,
  // descriptors met during the walk
  input wire logic desc_valid,
  input wire logic desc_long,
  input wire logic [2:0] desc_read_floor,
  input wire logic [2:0] desc_write_floor,
  input wire logic desc_write_lock,
  input wire logic desc_last,
  // new cache entry
  output logic entry_valid,
  output logic entry_fault_flag,
  output logic entry_write_lock
);

  // ==========================================================
  // level extraction from the top of an address
  function automatic level_t level_of(input logic [31:0] a, input logic [1:0] cnt);
    level_t l;
    l = 3'h0;
    case (cnt)
      2'h1: l = {2'h0, a[31]};
      2'h2: l = {1'h0, a[31:30]};
      2'h3: l = a[31:29];
      default: l = 3'h0;
    endcase
    return l;
  endfunction

  // ==========================================================
  // registers
  logic prot_enable_q;
  logic [1:0] level_count_select_q;
  level_t task_level_q;
  logic xlate_enable_q;
  logic [3:0] index_skip_count_q;
  logic [3:0] first_index_width_q;
  logic [31:0] user_table_root_q;
  logic [31:0] supervisor_table_root_q;
  logic [31:0] dma_table_root_q;
  level_t last_level_q;
  logic last_task_abort_q;
  logic last_fault_abort_q;
  logic last_wlock_abort_q;
  logic [15:0] abort_count_q;
  logic [31:0] reg_rdata_q;
  walk_state_t state_q, state_d;
  logic walk_start_q;
  logic [31:0] walk_root_q;
  logic [31:0] walk_index_q;
  logic [14:0] walk_first_q;
  level_t walk_level_q;
  logic [31:0] phys_addr_q;
  logic phys_valid_q;

  walk_check_if wk ();

  // ==========================================================
  // address decode
  wire wr_pc = reg_wr && (reg_addr == `OFF_PROT_CTRL);
  wire wr_tl = reg_wr && (reg_addr == `OFF_TASK_LEVEL);
  wire wr_ts = reg_wr && (reg_addr == `OFF_XLATE_SETUP);
  wire wr_ur = reg_wr && (reg_addr == `OFF_USER_ROOT);
  wire wr_sr = reg_wr && (reg_addr == `OFF_SUPER_ROOT);
  wire wr_dr = reg_wr && (reg_addr == `OFF_DMA_ROOT);

  // ==========================================================
  // bus cycle check
  wire levels_on = prot_enable_q && (level_count_select_q != 2'h0);
  wire level_t addr_level = level_of(cyc_addr, level_count_select_q);
  wire user_space = (cyc_func_code[3:2] == `SPACE_USER);
  wire supervisor_space = cyc_func_code[2];
  wire dma_space = cyc_func_code[3];
  // unsigned compare, larger means less privileged
  wire task_abort = cyc_valid && levels_on && user_space
                    && (addr_level > task_level_q);
  wire fault_abort = cyc_valid && !task_abort && cache_hit && cache_fault;
  wire wlock_abort = cyc_valid && !task_abort && cache_hit && !cache_fault
                     && cyc_write && cache_wlock;
  wire any_abort = task_abort || fault_abort || wlock_abort;

  // ==========================================================
  // walk setup
  // level bits stay in the index unless the skip count covers them
  wire levels_indexed = levels_on
                        && ({2'h0, level_count_select_q} > index_skip_count_q);
  wire [31:0] index_addr = cyc_addr << index_skip_count_q;
  wire [31:0] first_shift = `ADDR_BITS - {28'h0, first_index_width_q};
  wire [31:0] first_bits = (first_index_width_q == 4'h0) ? 32'h0
                           : (index_addr >> first_shift);
  // supervisor takes its own root even when its range overlaps user space
  wire [31:0] root_sel = dma_space ? dma_table_root_q
                         : supervisor_space ? supervisor_table_root_q
                         : user_table_root_q;
  wire start_ok = cyc_valid && !cache_hit && !task_abort && xlate_enable_q
                  && (state_q == WALK_IDLE);

  assign wk.start = start_ok;
  assign wk.level = addr_level;
  assign wk.check_floors = levels_on && !supervisor_space;
  assign wk.use_write_floor = !levels_indexed;
  assign wk.desc_valid = desc_valid && (state_q == WALK_BUSY);
  assign wk.desc_long = desc_long;
  assign wk.desc_read_floor = desc_read_floor;
  assign wk.desc_write_floor = desc_write_floor;
  assign wk.desc_write_lock = desc_write_lock;
  assign wk.desc_last = desc_last;

  walk_floor_tracker tracker (
    .ref_clk(ref_clk),
    .rst(rst),
    .wk(wk)
  );

  // ==========================================================
  // walk state
  always_comb begin
    state_d = state_q;
    case (state_q)
      WALK_IDLE: begin
        if (start_ok) begin
          state_d = WALK_BUSY;
        end
      end
      WALK_BUSY: begin
        if (wk.entry_valid) begin
          state_d = WALK_IDLE;
        end
      end
      default: state_d = WALK_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= WALK_IDLE;
      walk_start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      walk_start_q <= start_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      walk_root_q <= `ROOT_RESET;
      walk_index_q <= 32'h0;
      walk_first_q <= 15'h0;
      walk_level_q <= 3'h0;
    end else if (start_ok) begin
      walk_root_q <= root_sel;
      walk_index_q <= index_addr;
      walk_first_q <= first_bits[14:0];
      walk_level_q <= addr_level;
    end
  end

  // ==========================================================
  // physical address only for clean cache hits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phys_valid_q <= 1'b0;
      phys_addr_q <= 32'h0;
    end else begin
      phys_valid_q <= cyc_valid && cache_hit && !any_abort;
      if (cyc_valid && cache_hit && !any_abort) begin
        phys_addr_q <= cache_phys;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {level_count_select_q, prot_enable_q} <= `PROT_CTRL_RESET;
      task_level_q <= `TASK_LEVEL_RESET;
      {first_index_width_q, index_skip_count_q, xlate_enable_q} <= 9'h000;
    end else begin
      if (wr_pc) begin
        prot_enable_q <= reg_wdata[`PC_ENABLE_BIT];
        level_count_select_q <= reg_wdata[`PC_COUNT_MSB:`PC_COUNT_LSB];
      end
      if (wr_tl) begin
        task_level_q <= reg_wdata[2:0];
      end
      if (wr_ts) begin
        xlate_enable_q <= reg_wdata[`TS_ENABLE_BIT];
        index_skip_count_q <= reg_wdata[`TS_SKIP_MSB:`TS_SKIP_LSB];
        first_index_width_q <= reg_wdata[`TS_FIW_MSB:`TS_FIW_LSB];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      user_table_root_q <= `ROOT_RESET;
      supervisor_table_root_q <= `ROOT_RESET;
      dma_table_root_q <= `ROOT_RESET;
    end else begin
      if (wr_ur) begin
        user_table_root_q <= reg_wdata;
      end
      if (wr_sr) begin
        supervisor_table_root_q <= reg_wdata;
      end
      if (wr_dr) begin
        dma_table_root_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // abort record, updated by hardware only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_level_q <= 3'h0;
      last_task_abort_q <= 1'b0;
      last_fault_abort_q <= 1'b0;
      last_wlock_abort_q <= 1'b0;
      abort_count_q <= 16'h0;
    end else if (any_abort) begin
      last_level_q <= addr_level;
      last_task_abort_q <= task_abort;
      last_fault_abort_q <= fault_abort;
      last_wlock_abort_q <= wlock_abort;
      abort_count_q <= abort_count_q + 16'h1;
    end
  end

  // ==========================================================
  // read data, valid the cycle after the strobe
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  always_comb begin
    status_word = 32'h0;
    status_word[`ST_LEVEL_MSB:`ST_LEVEL_LSB] = last_level_q;
    status_word[`ST_TASK_ABORT_BIT] = last_task_abort_q;
    status_word[`ST_FAULT_ABORT_BIT] = last_fault_abort_q;
    status_word[`ST_WLOCK_ABORT_BIT] = last_wlock_abort_q;
    status_word[`ST_BUSY_BIT] = (state_q == WALK_BUSY);
    status_word[`ST_COUNT_MSB:`ST_COUNT_LSB] = abort_count_q;
  end

  always_comb begin
    case (reg_addr)
      `OFF_PROT_CTRL: rd_mux = {29'h0, level_count_select_q, prot_enable_q};
      `OFF_TASK_LEVEL: rd_mux = {29'h0, task_level_q};
      `OFF_XLATE_SETUP: rd_mux = {20'h0, first_index_width_q, index_skip_count_q,
                                  3'h0, xlate_enable_q};
      `OFF_USER_ROOT: rd_mux = user_table_root_q;
      `OFF_SUPER_ROOT: rd_mux = supervisor_table_root_q;
      `OFF_DMA_ROOT: rd_mux = dma_table_root_q;
      `OFF_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_q <= 32'h0;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = reg_rdata_q;
  assign bus_error = any_abort;
  assign phys_addr = phys_addr_q;
  assign phys_valid = phys_valid_q;
  assign walk_start = walk_start_q;
  assign walk_root = walk_root_q;
  assign walk_index_addr = walk_index_q;
  assign walk_first_index = walk_first_q;
  assign walk_level = walk_level_q;
  assign walk_busy = (state_q == WALK_BUSY);
  assign entry_valid = wk.entry_valid;
  assign entry_fault_flag = wk.entry_fault;
  assign entry_write_lock = wk.entry_wlock;

endmodule

// ### design/access_level_regs.svh
// register offsets, field positions and reset values of the access level checker
`ifndef ACCESS_LEVEL_REGS_SVH
`define ACCESS_LEVEL_REGS_SVH

// ==========================================================
// register byte offsets
`define OFF_PROT_CTRL 8'h00
`define OFF_TASK_LEVEL 8'h04
`define OFF_XLATE_SETUP 8'h08
`define OFF_USER_ROOT 8'h0c
`define OFF_SUPER_ROOT 8'h10
`define OFF_DMA_ROOT 8'h14
`define OFF_STATUS 8'h18

// ==========================================================
// protection_control fields
`define PC_ENABLE_BIT 0
`define PC_COUNT_LSB 1
`define PC_COUNT_MSB 2

// ==========================================================
// translation_setup fields
`define TS_ENABLE_BIT 0
`define TS_SKIP_LSB 4
`define TS_SKIP_MSB 7
`define TS_FIW_LSB 8
`define TS_FIW_MSB 11

// ==========================================================
// status fields
`define ST_LEVEL_LSB 0
`define ST_LEVEL_MSB 2
`define ST_TASK_ABORT_BIT 4
`define ST_FAULT_ABORT_BIT 5
`define ST_WLOCK_ABORT_BIT 6
`define ST_BUSY_BIT 7
`define ST_COUNT_LSB 16
`define ST_COUNT_MSB 31

// ==========================================================
// reset values and constants
`define PROT_CTRL_RESET 3'h0
`define TASK_LEVEL_RESET 3'h0
`define XLATE_SETUP_RESET 12'h000
`define ROOT_RESET 32'h0000_0000
`define LEVEL_LEAST_PRIV 3'h7
`define ADDR_BITS 32'd32
`define SPACE_USER 2'h0

`endif

// ### design/access_level_pkg.sv
// types shared by the access level checker modules
package access_level_pkg;

  typedef logic [2:0] level_t;

  typedef enum logic {
    WALK_IDLE,
    WALK_BUSY
  } walk_state_t;

endpackage

// ### design/walk_check_if.sv
// signals between the cycle checker and the walk floor tracker
`timescale 1ns/1ps
interface walk_check_if;
  import access_level_pkg::*;

  // walk setup
  logic start;
  level_t level;
  logic check_floors;
  logic use_write_floor;
  // descriptor stream
  logic desc_valid;
  logic desc_long;
  level_t desc_read_floor;
  level_t desc_write_floor;
  logic desc_write_lock;
  logic desc_last;
  // new cache entry
  logic entry_valid;
  logic entry_fault;
  logic entry_wlock;

  modport checker_side (
    output start, level, check_floors, use_write_floor,
    output desc_valid, desc_long, desc_read_floor, desc_write_floor,
    output desc_write_lock, desc_last,
    input entry_valid, entry_fault, entry_wlock
  );

  modport tracker_side (
    input start, level, check_floors, use_write_floor,
    input desc_valid, desc_long, desc_read_floor, desc_write_floor,
    input desc_write_lock, desc_last,
    output entry_valid, entry_fault, entry_wlock
  );
endinterface

// ### design/walk_floor_tracker.sv
// tracks the least read and write floors met during one table walk
`timescale 1ns/1ps
`include "access_level_regs.svh"
module walk_floor_tracker
  import access_level_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // walk side
  walk_check_if.tracker_side wk
);

  level_t min_rf_q, min_rf_d;
  level_t min_wf_q, min_wf_d;
  logic wl_q, wl_d;
  level_t lvl_q;
  logic chk_q;
  logic use_wf_q;
  logic entry_valid_q;
  logic entry_fault_q;
  logic entry_wlock_q;

  // ==========================================================
  // running minimum, long descriptors only carry floors
  wire long_desc = wk.desc_valid && wk.desc_long;
  wire rf_lower = long_desc && (wk.desc_read_floor < min_rf_q);
  wire wf_lower = long_desc && (wk.desc_write_floor < min_wf_q);
  assign min_rf_d = rf_lower ? wk.desc_read_floor : min_rf_q;
  assign min_wf_d = wf_lower ? wk.desc_write_floor : min_wf_q;
  assign wl_d = wl_q || (wk.desc_valid && wk.desc_write_lock);

  // ==========================================================
  // verdict for the new cache entry
  wire read_fail = chk_q && (lvl_q > min_rf_d);
  wire write_fail = chk_q && use_wf_q && (lvl_q > min_wf_d);
  // a failed read check also locks writes
  wire wlock_now = wl_d || write_fail || read_fail;

  always_ff @(posedge ref_clk) begin
    if (rst || wk.start) begin
      min_rf_q <= `LEVEL_LEAST_PRIV;
      min_wf_q <= `LEVEL_LEAST_PRIV;
      wl_q <= 1'b0;
    end else if (wk.desc_valid) begin
      min_rf_q <= min_rf_d;
      min_wf_q <= min_wf_d;
      wl_q <= wl_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lvl_q <= 3'h0;
      chk_q <= 1'b0;
      use_wf_q <= 1'b0;
    end else if (wk.start) begin
      lvl_q <= wk.level;
      chk_q <= wk.check_floors;
      use_wf_q <= wk.use_write_floor;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      entry_valid_q <= 1'b0;
      entry_fault_q <= 1'b0;
      entry_wlock_q <= 1'b0;
    end else begin
      entry_valid_q <= wk.desc_valid && wk.desc_last;
      if (wk.desc_valid && wk.desc_last) begin
        entry_fault_q <= read_fail;
        entry_wlock_q <= wlock_now;
      end
    end
  end

  assign wk.entry_valid = entry_valid_q;
  assign wk.entry_fault = entry_fault_q;
  assign wk.entry_wlock = entry_wlock_q;

endmodule

// ### verification/alpc_sva.sv
// concurrent checks on the ports of the access level checker
`timescale 1ns/1ps
`include "access_level_regs.svh"
module alpc_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // bus cycle
  input wire logic cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire logic [3:0] cyc_func_code,
  input wire logic cyc_write,
  input wire logic bus_error,
  input wire logic [31:0] phys_addr,
  input wire logic phys_valid,
  input wire logic cache_hit,
  input wire logic cache_fault,
  input wire logic cache_wlock,
  input wire logic [31:0] cache_phys,
  // walk
  input wire logic walk_start,
  input wire logic walk_busy,
  input wire logic desc_valid,
  input wire logic desc_last,
  input wire logic entry_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // shadow copies of the registers that steer the checks
  logic [2:0] prot_q;
  logic [2:0] task_q;
  logic xl_en_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prot_q <= `PROT_CTRL_RESET;
      task_q <= `TASK_LEVEL_RESET;
      xl_en_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `OFF_PROT_CTRL) prot_q <= reg_wdata[2:0];
      if (reg_addr == `OFF_TASK_LEVEL) task_q <= reg_wdata[2:0];
      if (reg_addr == `OFF_XLATE_SETUP) xl_en_q <= reg_wdata[0];
    end
  end
  wire user_lvl3 = cyc_valid && prot_q == 3'h7 && cyc_func_code[3:2] == `SPACE_USER;
  wire user_above = user_lvl3 && cyc_addr[31:29] > task_q;
  // ==========================================================
  // assertions
  task_abort_a: assert property (user_above |-> bus_error)
    else $error("user level above task level not aborted");
  task_pass_a: assert property (user_lvl3 && !cache_hit && !user_above |-> !bus_error)
    else $error("permitted user level aborted");
  super_skip_a: assert property (cyc_valid && !cache_hit && cyc_func_code[3:2] != 2'h0
    |-> !bus_error)
    else $error("supervisor or dma cycle aborted on task level");
  fault_abort_a: assert property (cyc_valid && cache_hit && cache_fault |-> bus_error)
    else $error("faulted entry not aborted");
  wlock_abort_a: assert property (cyc_valid && cache_hit && cache_wlock && cyc_write
    |-> bus_error)
    else $error("write to locked entry not aborted");
  abort_quiet_a: assert property (bus_error |=> !phys_valid && !walk_start)
    else $error("aborted cycle produced output");
  hit_phys_a: assert property (cyc_valid && cache_hit && !bus_error
    |=> phys_valid && phys_addr == $past(cache_phys))
    else $error("clean hit gave no physical address");
  miss_walk_a: assert property (cyc_valid && !cache_hit && !bus_error && xl_en_q && !walk_busy
    |=> walk_start && walk_busy)
    else $error("accepted miss started no walk");
  entry_after_a: assert property (walk_busy && desc_valid && desc_last
    |=> entry_valid ##1 !walk_busy)
    else $error("entry not written after last descriptor");
endmodule

// ### verification/cpu_bus_model.sv
// host processor model presenting logical bus cycles
`timescale 1ns/1ps
module cpu_bus_model (
  // clock
  input wire logic ref_clk,
  // bus cycle
  output logic cyc_valid,
  output logic [31:0] cyc_addr,
  output logic [3:0] cyc_func_code,
  output logic cyc_write
);
  initial begin
    cyc_valid = 1'b0;
    cyc_addr = 32'h0;
    cyc_func_code = 4'h0;
    cyc_write = 1'b0;
  end
  // ==========================================================
  // one cycle stands from just after an edge to the next edge
  task automatic present(input logic [31:0] a, input logic [3:0] fc, input logic wr);
    @(posedge ref_clk);
    cyc_valid <= 1'b1;
    cyc_addr <= a;
    cyc_func_code <= fc;
    cyc_write <= wr;
  endtask
  // released address and write lines must not keep showing the last value; the function code keeps it
  task automatic end_cycle();
    @(posedge ref_clk);
    cyc_valid <= 1'b0;
    cyc_addr <= ~cyc_addr;
    cyc_write <= ~cyc_write;
  endtask
endmodule

// ### verification/tb_access_level_protection_check.sv
// self-checking bench for the access level protection checker
`timescale 1ns/1ps
`include "access_level_regs.svh"
module tb_access_level_protection_check;
  import access_level_pkg::*;
  // ==========================================================
  // clock, reset and ports
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cache_hit = 1'b0;
  logic cache_fault = 1'b0;
  logic cache_wlock = 1'b0;
  logic [31:0] cache_phys = 32'h0;
  logic desc_valid = 1'b0;
  logic desc_long = 1'b0;
  logic [2:0] desc_read_floor = 3'h0;
  logic [2:0] desc_write_floor = 3'h0;
  logic desc_write_lock = 1'b0;
  logic desc_last = 1'b0;
  logic cyc_valid, cyc_write, bus_error, phys_valid, walk_start, walk_busy;
  logic entry_valid, entry_fault_flag, entry_write_lock;
  logic [3:0] cyc_func_code;
  logic [31:0] cyc_addr, reg_rdata, phys_addr, walk_root, walk_index_addr;
  logic [14:0] walk_first_index;
  logic [2:0] walk_level;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic be, pv, ws;
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  access_level_protection_check DUT (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cyc_valid, .cyc_addr, .cyc_func_code, .cyc_write, .bus_error,
    .phys_addr, .phys_valid, .cache_hit, .cache_fault, .cache_wlock, .cache_phys,
    .walk_start, .walk_root, .walk_index_addr, .walk_first_index, .walk_level, .walk_busy,
    .desc_valid, .desc_long, .desc_read_floor, .desc_write_floor, .desc_write_lock,
    .desc_last, .entry_valid, .entry_fault_flag, .entry_write_lock);
  cpu_bus_model cpu (.ref_clk, .cyc_valid, .cyc_addr, .cyc_func_code, .cyc_write);
  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  // hfw holds cache hit, fault and write lock
  task automatic cyc(input logic [31:0] a, input logic [3:0] fc, input logic w,
                     input logic [2:0] hfw);
    cpu.present(a, fc, w);
    {cache_hit, cache_fault, cache_wlock} <= hfw;
    cache_phys <= ~a;
    #1 be = bus_error;
    cpu.end_cycle();
    {cache_hit, cache_fault, cache_wlock} <= 3'h0;
    #1 pv = phys_valid;
    ws = walk_start;
  endtask
  task automatic desc(input logic [2:0] rf, input logic [2:0] wf, input logic wl,
                      input logic last);
    @(posedge ref_clk);
    desc_valid <= 1'b1;
    desc_long <= 1'b1;
    desc_read_floor <= rf;
    desc_write_floor <= wf;
    desc_write_lock <= wl;
    desc_last <= last;
  endtask
  task automatic walk(input logic [3:0] fc, input logic [2:0] rf0, input logic [2:0] wf0,
                      input logic [2:0] rf1, input logic wl, input logic [31:0] root,
                      input logic [1:0] exp_fw);
    cyc(32'h4000_1234, fc, 1'b0, 3'h0);
    chk("walk_start", 1, ws);
    chk("walk_root", root, walk_root);
    desc(rf0, wf0, 1'b0, 1'b0);
    desc(rf1, 3'h7, wl, 1'b1);
    @(posedge ref_clk);
    desc_valid <= 1'b0;
    desc_read_floor <= ~desc_read_floor;
    desc_write_floor <= ~desc_write_floor;
    #1 chk("entry_valid", 1, entry_valid);
    chk("entry flags", exp_fw, {entry_fault_flag, entry_write_lock});
    @(posedge ref_clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_reset();
    rchk(`OFF_PROT_CTRL, {29'h0, `PROT_CTRL_RESET}, "protection_control");
    rchk(`OFF_TASK_LEVEL, {29'h0, `TASK_LEVEL_RESET}, "task level");
    rchk(`OFF_XLATE_SETUP, {20'h0, `XLATE_SETUP_RESET}, "translation_setup");
    rchk(`OFF_DMA_ROOT, `ROOT_RESET, "dma_table_root");
    rchk(8'h1c, 32'h0, "unmapped read");
    wr(`OFF_USER_ROOT, 32'h0000_1000);
    wr(`OFF_SUPER_ROOT, 32'h0000_2000);
    wr(`OFF_DMA_ROOT, 32'h0000_3000);
    rchk(`OFF_SUPER_ROOT, 32'h0000_2000, "supervisor_table_root");
  endtask
  task automatic s_task();
    wr(`OFF_PROT_CTRL, 32'h7);
    wr(`OFF_TASK_LEVEL, 32'h3);
    for (int l = 0; l < 8; l++) begin
      cyc({l[2:0], 29'h10}, 4'h1, 1'b0, 3'h4);
      chk("user level abort", l > 3, be);
      chk("hit phys_valid", l <= 3, pv);
    end
    chk("phys_addr", ~32'h6000_0010, phys_addr);
    cyc(32'he000_0000, 4'h5, 1'b1, 3'h0);
    chk("supervisor abort", 0, be);
    cyc(32'he000_0000, 4'h9, 1'b0, 3'h0);
    chk("dma abort", 0, be);
    wr(`OFF_PROT_CTRL, 32'h3);
    wr(`OFF_TASK_LEVEL, 32'h0);
    cyc(32'h8000_0000, 4'h1, 1'b0, 3'h0);
    chk("one level bit abort", 1, be);
    cyc(32'h4000_0000, 4'h1, 1'b0, 3'h0);
    chk("one level bit pass", 0, be);
    wr(`OFF_PROT_CTRL, 32'h5);
    cyc(32'h4000_0000, 4'h1, 1'b0, 3'h0);
    chk("two level bits abort", 1, be);
    wr(`OFF_PROT_CTRL, 32'h6);
    cyc(32'he000_0000, 4'h1, 1'b0, 3'h0);
    chk("levels disabled", 0, be);
  endtask
  task automatic s_cache();
    wr(`OFF_PROT_CTRL, 32'h7);
    wr(`OFF_TASK_LEVEL, 32'h7);
    cyc(32'h2000_0040, 4'h1, 1'b0, 3'h6);
    chk("fault hit abort", 2'b10, {be, pv});
    cyc(32'h2000_0040, 4'h1, 1'b1, 3'h5);
    chk("locked write abort", 2'b10, {be, pv});
    cyc(32'h2000_0040, 4'h1, 1'b0, 3'h5);
    chk("locked read", 2'b01, {be, pv});
    rchk(`OFF_STATUS, 32'h0008_0041, "status");
  endtask
  task automatic s_walk();
    wr(`OFF_XLATE_SETUP, 32'h301);
    walk(4'h1, 3'h5, 3'h7, 3'h1, 1'b0, 32'h1000, 2'b11);
    chk("walk_level", 3'h2, walk_level);
    chk("walk_first_index", 15'h0002, walk_first_index);
    chk("walk_index_addr", 32'h4000_1234, walk_index_addr);
    walk(4'h1, 3'h4, 3'h0, 3'h4, 1'b0, 32'h1000, 2'b00);
    walk(4'h1, 3'h7, 3'h7, 3'h7, 1'b1, 32'h1000, 2'b01);
    wr(`OFF_XLATE_SETUP, 32'h331);
    walk(4'h1, 3'h4, 3'h1, 3'h7, 1'b0, 32'h1000, 2'b01);
    chk("skipped index addr", 32'h0000_91a0, walk_index_addr);
    walk(4'h5, 3'h0, 3'h0, 3'h0, 1'b0, 32'h2000, 2'b00);
    walk(4'h9, 3'h1, 3'h7, 3'h7, 1'b0, 32'h3000, 2'b11);
  endtask
  // ==========================================================
  // sequence, watchdog and verdict
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    s_reset();
    s_task();
    s_cache();
    s_walk();
    end_sim();
  end
endmodule

bind access_level_protection_check alpc_sva u_sva (.ref_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .cyc_valid, .cyc_addr, .cyc_func_code, .cyc_write, .bus_error, .phys_addr,
  .phys_valid, .cache_hit, .cache_fault, .cache_wlock, .cache_phys, .walk_start,
  .walk_busy, .desc_valid, .desc_last, .entry_valid);
